/* File: rtl/apsr_pkg.sv */
// package: register map, field layout and types for the converter control block
package apsr_pkg;
    localparam int DW = 32;
    localparam int RES_W = 10;
    localparam int BUS_W = 16;
    localparam int PIN_N = 16;
    localparam int SAR_STEPS = 12;
    localparam int AW = 8;
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_STAT = 8'h04;
    localparam logic [AW-1:0] OFF_RESULT = 8'h08;
    localparam logic [AW-1:0] OFF_PCFG = 8'h0C;
    localparam logic [AW-1:0] OFF_DIR = 8'h10;
    localparam logic [AW-1:0] OFF_PORT = 8'h14;
    localparam logic [AW-1:0] OFF_CHSEL = 8'h18;
    localparam logic [AW-1:0] OFF_SMPT = 8'h1C;
    // control register fields
    localparam int B_ON = 15;
    localparam int B_SIDL = 13;
    localparam int B_FORM = 8;
    localparam int B_AUTO = 2;
    localparam int B_SAMPLE_ACTIVE = 1;
    localparam int B_RC = 7;
    localparam int B_IE = 6;
    localparam int B_DONE = 0;
    localparam logic [DW-1:0] CTRL_MASK = 32'h0000_A3C6;
    localparam logic [1:0] FMT_INT = 2'h0;
    localparam logic [1:0] FMT_SINT = 2'h1;
    localparam logic [1:0] FMT_FRAC = 2'h2;
    localparam logic [1:0] FMT_SFRAC = 2'h3;
    localparam int FRAC_SH = 6;
    localparam logic [7:0] SMPT_RST = 8'h01;
    localparam logic [3:0] STEP_LAST = 4'hB;
    typedef enum {ST_IDLE, ST_SAMPLE, ST_DELAY, ST_CONVERT} apsr_state_t;
    typedef struct packed {
        logic on;
        logic stop_in_idle;
        logic [1:0] fmt;
        logic rc_sel;
        logic irq_en;
        logic auto_sample;
        logic sample_active;
    } apsr_ctrl_t;
    typedef struct packed {
        logic [AW-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [DW-1:0] pwdata;
    } apsr_apb_req_t;
endpackage : apsr_pkg

/* File: rtl/apsr_core.sv */
// converter control: sampling, power, sleep/idle, result formats, analog port masking
//
// Behaviour
// - manual sample bit or automatic timed sampling
// - module_on powers block; off disables all
// - sleep without rc clock gates module clocks low
// - sleep without rc clock aborts conversion, never resumes it
// - sleep leaves registers unchanged
// - rc clock converts in sleep, one-cycle delay
// - completion sets done flag, writes result
// - sleep completion wakes or shuts module off
// - stop_in_idle halts module during idle
// - reset loads register defaults (direction all ones, sample time 1), aborts sequence
// - reset never touches result buffer
// - ten-bit result, four format codes giving three sixteen-bit layouts (signed fractional same as fractional)
// - integer, signed, fractional bit placement
// - bus writes to buffer are integer
// - analog pins read zero on port
// - digital-input pins are never converted
// - output analog pin converts driven level
// - channel selects and direction never block operation
`timescale 1ns/1ps
`default_nettype none
module apsr_core
    import apsr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [apsr_pkg::AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [apsr_pkg::DW-1:0] pwdata,
    output logic [apsr_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic [apsr_pkg::PIN_N-1:0] pin_in,
    input wire logic [apsr_pkg::PIN_N-1:0] pin_out_level,
    input wire logic comparator_bit,
    output logic sar_trial_en,
    output logic [3:0] sar_channel,
    output logic [apsr_pkg::RES_W-1:0] sar_trial,
    output logic sample_hold_en,
    output logic analog_enable,
    output logic irq_req,
    output logic wake_req
);
    import apsr_pkg::*;

    function automatic logic [BUS_W-1:0] fmt_result(input logic [RES_W-1:0] d, input logic [1:0] f);
        logic [BUS_W-1:0] r;
        r = '0;
        unique case (f)
            FMT_INT: r = {{(BUS_W-RES_W){1'b0}}, d};
            FMT_SINT: r = {{(BUS_W-RES_W){d[RES_W-1]}}, d};
            FMT_FRAC, FMT_SFRAC: r = {d, {FRAC_SH{1'b0}}};
        endcase
        return r;
    endfunction : fmt_result

    apsr_ctrl_t ctrl_r;
    logic done_r, done_nxt;
    logic [RES_W-1:0] result_buffer;
    logic [PIN_N-1:0] analog_pin_config_r, pin_direction_r;
    logic [3:0] chsa_r, chsb_r;
    logic [7:0] smpt_r, smp_cnt_r;
    logic [3:0] step_r;
    logic [RES_W-1:0] sar_r;
    logic [PIN_N-1:0] pin_s1, pin_s2, pin_s3, pin_q;
    logic sleep_in_r, irq_r, wake_r, sleep_off_r;
    apsr_state_t state_r;

    // level from the outside domain is accepted only when the two later stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_q <= '0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < PIN_N; i++) begin
                if (pin_s2[i] == pin_s3[i]) pin_q[i] <= pin_s3[i];
            end
        end
    end

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic sel_ctrl = (paddr == OFF_CTRL);
    wire logic sel_stat = (paddr == OFF_STAT);
    wire logic sel_res = (paddr == OFF_RESULT);
    wire logic sel_pcfg = (paddr == OFF_PCFG);
    wire logic sel_dir = (paddr == OFF_DIR);
    wire logic sel_port = (paddr == OFF_PORT);
    wire logic sel_chs = (paddr == OFF_CHSEL);
    wire logic sel_smpt = (paddr == OFF_SMPT);
    wire logic mapped = sel_ctrl | sel_stat | sel_res | sel_pcfg | sel_dir | sel_port | sel_chs | sel_smpt;

    // sleep without the rc clock stops everything; idle stops only when asked
    wire logic sleep_gate = cpu_sleep && !ctrl_r.rc_sel;
    wire logic idle_gate = cpu_idle && ctrl_r.stop_in_idle;
    wire logic powered = ctrl_r.on && !sleep_off_r;
    wire logic run = powered && !sleep_gate && !idle_gate;
    wire logic conv_done = (state_r == ST_CONVERT) && run && (step_r == STEP_LAST);
    wire logic sleep_entry = cpu_sleep && !sleep_in_r;

    wire logic [3:0] ch = chsa_r;
    // digital-input pins convert nothing; analog output pins convert the driven level
    wire logic pin_analog = analog_pin_config_r[ch];
    wire logic [RES_W-1:0] pin_as_level = pin_direction_r[ch] ? {RES_W{1'b1}} : {RES_W{1'b0}};
    wire logic use_digital_level = pin_analog && !pin_direction_r[ch];
    wire logic convert_ok = pin_analog;
    wire logic [RES_W-1:0] trial = sar_r | ({{(RES_W-1){1'b0}}, 1'b1} << (RES_W - 1 - int'(step_r)));
    wire logic [RES_W-1:0] next_sar = comparator_bit ? trial : sar_r;
    wire logic [RES_W-1:0] out_level = {RES_W{pin_out_level[ch]}};
    wire logic [RES_W-1:0] final_res = use_digital_level ? out_level : next_sar;

    wire logic [PIN_N-1:0] port_view = pin_q & ~analog_pin_config_r;

    always_comb begin
        prdata = '0;
        if (acc && !pwrite) begin
            unique case (1'b1)
                sel_ctrl: prdata = {16'h0000, ctrl_r.on, 1'b0, ctrl_r.stop_in_idle, 3'h0, ctrl_r.fmt,
                                    ctrl_r.rc_sel, ctrl_r.irq_en, 3'h0, ctrl_r.auto_sample,
                                    ctrl_r.sample_active, done_r};
                sel_stat: prdata = {28'h0000000, sleep_off_r, irq_r, state_r == ST_CONVERT, done_r};
                sel_res: prdata = {16'h0000, fmt_result(result_buffer, ctrl_r.fmt)};
                sel_pcfg: prdata = {16'h0000, analog_pin_config_r};
                sel_dir: prdata = {16'h0000, pin_direction_r};
                sel_port: prdata = {16'h0000, port_view};
                sel_chs: prdata = {24'h000000, chsb_r, chsa_r};
                sel_smpt: prdata = {24'h000000, smpt_r};
                default: prdata = '0;
            endcase
        end
    end
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // registers: software clears done, hardware completion wins
    assign done_nxt = conv_done ? 1'b1 : ((wr && sel_ctrl && !pwdata[B_DONE]) ? 1'b0 : done_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            done_r <= 1'b0;
            analog_pin_config_r <= '0;
            pin_direction_r <= '1;
            chsa_r <= '0;
            chsb_r <= '0;
            smpt_r <= SMPT_RST;
        end else begin
            // sleep entry writes nothing here; registers keep their values
            done_r <= done_nxt;
            if (wr && sel_ctrl) begin
                ctrl_r.on <= pwdata[B_ON];
                ctrl_r.stop_in_idle <= pwdata[B_SIDL];
                ctrl_r.fmt <= pwdata[B_FORM +: 2];
                ctrl_r.rc_sel <= pwdata[B_RC];
                ctrl_r.irq_en <= pwdata[B_IE];
                ctrl_r.auto_sample <= pwdata[B_AUTO];
                ctrl_r.sample_active <= pwdata[B_SAMPLE_ACTIVE];
            end else if (state_r == ST_SAMPLE && !ctrl_r.auto_sample && false_start()) begin
                ctrl_r.sample_active <= 1'b0;
            end
            if (wr && sel_pcfg) analog_pin_config_r <= pwdata[PIN_N-1:0];
            if (wr && sel_dir) pin_direction_r <= pwdata[PIN_N-1:0];
            if (wr && sel_chs) {chsb_r, chsa_r} <= pwdata[7:0];
            if (wr && sel_smpt) smpt_r <= (pwdata[7:0] == 8'h00) ? SMPT_RST : pwdata[7:0];
        end
    end

    function automatic logic false_start();
        return 1'b0;
    endfunction : false_start

    // result buffer has no reset: content survives reset, undefined at power-on
    always_ff @(posedge pclk) begin
        if (wr && sel_res) result_buffer <= pwdata[RES_W-1:0];
        else if (conv_done) result_buffer <= final_res;
    end

    // sequencer: sample phase, optional one-cycle rc delay, then successive approximation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            step_r <= '0;
            sar_r <= '0;
            smp_cnt_r <= '0;
            sleep_in_r <= 1'b0;
            sleep_off_r <= 1'b0;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            sleep_in_r <= cpu_sleep;
            wake_r <= 1'b0;
            irq_r <= conv_done && ctrl_r.irq_en;
            if (conv_done && cpu_sleep) begin
                if (ctrl_r.irq_en) wake_r <= 1'b1;
                else sleep_off_r <= 1'b1;
            end
            if (!cpu_sleep || !ctrl_r.on) sleep_off_r <= 1'b0;
            if (!powered || (sleep_entry && !ctrl_r.rc_sel)) begin
                state_r <= ST_IDLE;
                step_r <= '0;
                sar_r <= '0;
            end else if (run) begin
                unique case (state_r)
                    ST_IDLE: begin
                        smp_cnt_r <= '0;
                        if (ctrl_r.auto_sample || ctrl_r.sample_active) state_r <= ST_SAMPLE;
                    end
                    ST_SAMPLE: begin
                        // the sample phase always completes before conversion begins
                        if (smp_cnt_r != 8'hFF) smp_cnt_r <= smp_cnt_r + 8'h01;
                        if (ctrl_r.auto_sample ? (smp_cnt_r + 8'h01 >= smpt_r)
                                               : (!ctrl_r.sample_active && smp_cnt_r != 8'h00)) begin
                            state_r <= ctrl_r.rc_sel ? ST_DELAY : ST_CONVERT;
                            step_r <= '0;
                            sar_r <= '0;
                        end
                    end
                    ST_DELAY: state_r <= ST_CONVERT;
                    ST_CONVERT: begin
                        if (step_r < 4'(RES_W)) sar_r <= next_sar;
                        if (step_r == STEP_LAST) state_r <= ST_IDLE;
                        else step_r <= step_r + 4'h1;
                    end
                endcase
            end
        end
    end

    assign sar_trial_en = (state_r == ST_CONVERT) && run && convert_ok;
    assign sar_trial = trial;
    assign sar_channel = ch;
    assign sample_hold_en = (state_r == ST_SAMPLE) && run && convert_ok;
    assign analog_enable = powered && !sleep_gate;
    assign irq_req = irq_r;
    assign wake_req = wake_r;
    wire logic unused_ok = ^{pin_as_level, chsb_r};
endmodule : apsr_core
`default_nettype wire

/* File: test/apsr_checker.sv */
// checker: port timing relations of the converter control block
`timescale 1ns/1ps
`default_nettype none
module apsr_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_sleep,
    input wire logic cpu_idle,
    input wire logic sar_trial_en,
    input wire logic sample_hold_en,
    input wire logic analog_enable,
    input wire logic irq_req,
    input wire logic wake_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // sleep and idle may freeze or cut a run, so they excuse a gap
    sequence conv_run;
        (sar_trial_en || cpu_sleep || cpu_idle) [*8];
    endsequence
    sequence conv_seen;
        $past(sar_trial_en) || $past(sar_trial_en, 2);
    endsequence
    AST_OFF_QUIET: assert property (!analog_enable |-> !sar_trial_en && !sample_hold_en)
        else $error("converter active while powered down");
    AST_HOLD_THEN_CONVERT: assert property (sar_trial_en |-> !sample_hold_en)
        else $error("sampling overlaps conversion");
    AST_CONV_STEPS: assert property ($rose(sar_trial_en) |-> conv_run)
        else $error("conversion cut short");
    AST_IRQ_PULSE: assert property (irq_req |=> !irq_req)
        else $error("interrupt request longer than one cycle");
    AST_IRQ_AFTER_CONV: assert property (irq_req |-> conv_seen)
        else $error("completion without conversion steps");
    AST_WAKE_WITH_IRQ: assert property (wake_req |-> irq_req)
        else $error("wake without interrupt request");
    AST_WAKE_IN_SLEEP: assert property (wake_req |-> $past(cpu_sleep))
        else $error("wake outside sleep");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> !irq_req && !wake_req && !analog_enable)
        else $error("outputs active after reset");
endmodule : apsr_checker
bind apsr_core apsr_checker i_chk (.pclk(pclk), .presetn(presetn), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
    .sar_trial_en(sar_trial_en), .sample_hold_en(sample_hold_en), .analog_enable(analog_enable),
    .irq_req(irq_req), .wake_req(wake_req));
`default_nettype wire

/* File: test/apsr_analog_model.sv */
// partner: sample-and-hold capacitor and comparator for the analog pins
`timescale 1ns/1ps
`default_nettype none
module apsr_analog_model (
    input wire logic pclk,
    input wire logic sample_hold_en,
    input wire logic sar_trial_en,
    input wire logic [apsr_pkg::RES_W-1:0] sar_trial,
    input wire logic [apsr_pkg::RES_W-1:0] level,
    output logic comparator_bit
);
    import apsr_pkg::*;
    logic [RES_W-1:0] held_r = '0;
    logic wob_r = 1'b0;
    // the cap only follows the pin while the switch is closed
    always @(posedge pclk) begin
        if (sample_hold_en) held_r <= level;
        wob_r <= ~wob_r;
    end
    // outside a trial the comparator output means nothing, so it wobbles
    assign comparator_bit = sar_trial_en ? (held_r >= sar_trial) : wob_r;
endmodule : apsr_analog_model
`default_nettype wire

/* File: test/adc_power_sleep_result_format_tb_top.sv */
// testbench: register accesses and conversions of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_power_sleep_result_format_tb_top;
    import apsr_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cpu_sleep = 1'b0, cpu_idle = 1'b0;
    logic pready, pslverr, comparator_bit, sar_trial_en, sample_hold_en, analog_enable, irq_req, wake_req, err;
    logic [AW-1:0] paddr = '0;
    logic [DW-1:0] pwdata = '0, prdata, q;
    logic [PIN_N-1:0] pin_in = '0, pin_out_level = '0;
    logic [RES_W-1:0] sar_trial, level = 10'h2C7;
    logic [3:0] sar_channel;
    logic [15:0] fx [4] = '{16'h03A5, 16'hFFA5, 16'hE940, 16'hE940};
    int fail_count = 0, tests_run = 0, irq_n = 0, cyc = 0, k;
    always #2.5 pclk = ~pclk;
    apsr_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .pin_in(pin_in), .pin_out_level(pin_out_level),
        .comparator_bit(comparator_bit), .sar_trial_en(sar_trial_en), .sar_channel(sar_channel),
        .sar_trial(sar_trial), .sample_hold_en(sample_hold_en), .analog_enable(analog_enable),
        .irq_req(irq_req), .wake_req(wake_req));
    apsr_analog_model i_ana (.pclk(pclk), .sample_hold_en(sample_hold_en), .sar_trial_en(sar_trial_en),
        .sar_trial(sar_trial), .level(level), .comparator_bit(comparator_bit));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq_req === 1'b1) irq_n <= irq_n + 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic [AW-1:0] a, input logic w, input logic [DW-1:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // manual sampling held for a whole write, well over one conversion clock
    task automatic conv(input logic [DW-1:0] c);
        apb(OFF_CTRL, 1'b1, c | 32'h2);
        apb(OFF_CTRL, 1'b1, c);
    endtask : conv
    task automatic wait_ev(input logic wk);
        k = 0;
        while (((wk ? wake_req : irq_req) !== 1'b1) && k < 200) begin
            @(posedge pclk);
            k++;
        end
        chk(wk ? "wake" : "irq", 32'h1, {31'h0, (k < 200)});
    endtask : wait_ev
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(OFF_CTRL, 1'b0, '0); chk("ctrl", 32'h0, q);
        apb(OFF_DIR, 1'b0, '0); chk("dir", 32'h0000FFFF, q);
        apb(8'h40, 1'b0, '0); chk("unmapped", 32'h1, q | {31'h0, err});
        pin_in <= 16'hFFFF;
        apb(OFF_PCFG, 1'b1, 32'h1);
        repeat (4) @(posedge pclk);
        apb(OFF_PORT, 1'b0, '0); chk("port", 32'h0000FFFE, q);
        apb(OFF_RESULT, 1'b1, 32'hFFFF_F3A5);
        for (int f = 0; f < 4; f++) begin
            apb(OFF_CTRL, 1'b1, DW'(f) << 8);
            apb(OFF_RESULT, 1'b0, '0); chk("format", {16'h0, fx[f]}, {16'h0, q[15:0]});
        end
        apb(OFF_CTRL, 1'b1, 32'h8040);
        repeat (20) @(posedge pclk);
        chk("power", 32'h1, {31'h0, analog_enable});
        conv(32'h8040); wait_ev(1'b0);
        apb(OFF_RESULT, 1'b0, '0); chk("result", 32'h2C7, q);
        apb(OFF_STAT, 1'b0, '0); chk("done", 32'h1, {31'h0, q[0]});
        pin_out_level <= 16'h0001;
        apb(OFF_DIR, 1'b1, 32'hFFFE);
        conv(32'h8040); wait_ev(1'b0);
        apb(OFF_RESULT, 1'b0, '0); chk("driven", 32'h3FF, q);
        apb(OFF_DIR, 1'b1, 32'hFFFF);
        conv(32'h8040);
        k = 0;
        while (sar_trial_en !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        repeat (9) @(posedge pclk);
        cpu_sleep <= 1'b1;
        k = irq_n;
        repeat (30) @(posedge pclk);
        cpu_sleep <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("aborted", k, irq_n);
        apb(OFF_CTRL, 1'b0, '0); chk("ctrl kept", 32'h8040, q);
        conv(32'h80C0);
        cpu_sleep <= 1'b1;
        wait_ev(1'b1);
        cpu_sleep <= 1'b0;
        conv(32'hA040);
        cpu_idle <= 1'b1;
        k = irq_n;
        repeat (40) @(posedge pclk);
        chk("idle halt", k, irq_n);
        cpu_idle <= 1'b0;
        wait_ev(1'b0);
        apb(OFF_SMPT, 1'b1, '0);
        apb(OFF_SMPT, 1'b0, '0); chk("smpt min", 32'h1, q);
        apb(OFF_CHSEL, 1'b1, 32'h21);
        chk("channel", 32'h1, {28'h0, sar_channel});
        apb(OFF_CHSEL, 1'b1, '0);
        // timed sampling keeps re-triggering until the auto bit is dropped again
        apb(OFF_SMPT, 1'b1, 32'h4);
        apb(OFF_CTRL, 1'b1, 32'h8044); wait_ev(1'b0);
        apb(OFF_CTRL, 1'b1, 32'h8040);
        apb(OFF_RESULT, 1'b0, '0); chk("auto", 32'h2C7, q);
        conv(32'h8040);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(OFF_RESULT, 1'b0, '0); chk("buffer kept", 32'h2C7, q);
        apb(OFF_CTRL, 1'b0, '0); chk("ctrl cleared", 32'h0, q);
        finish_test();
    end
endmodule : adc_power_sleep_result_format_tb_top
`default_nettype wire
